// file: core/rcb_pkg.sv
// Package with constants and types for the reset-cause and backup-domain supervisor.
package rcb_pkg;
  // Register offsets on the plain register port.
  localparam logic [2:0] ADDR_CAUSE  = 3'h0;
  localparam logic [2:0] ADDR_SW_RESET_REQUEST  = 3'h1;
  localparam logic [2:0] ADDR_BKCTRL = 3'h2;
  localparam logic [2:0] ADDR_BKSTAT = 3'h3;
  localparam logic [2:0] ADDR_BKREG0 = 3'h4;
  localparam logic [2:0] ADDR_BKREG1 = 3'h5;
  // Reset-cause flag positions.
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_PIN = 1;
  localparam int CAUSE_BOD = 2;
  localparam int CAUSE_WDT = 3;
  localparam int CAUSE_DBG = 4;
  localparam int CAUSE_SW  = 5;
  // Power-on reset value of the cause flags.
  localparam logic [5:0] CAUSE_RST = 6'h01;
  // Software reset request position.
  localparam int SW_RESET_REQUEST_BIT = 0;
  // Backup control field positions.
  localparam int BK_RST  = 0;
  localparam int BK_ACC  = 1;
  localparam int BK_FDEN = 2;
  localparam int BK_XEN  = 3;
  localparam int BK_XSEL = 4;
  localparam int BK_HESR = 5;
  // Backup status field positions.
  localparam int ST_PODF = 0;
  localparam int ST_BODF = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RDY  = 3;
  localparam int ST_ABS  = 7;
  // Clock period of ref_clk in ns.
  localparam int CLK_NS = 10;
  // Time of 64 lost swings at 32.768 kHz, in ns.
  localparam int FAIL_NS = 1953125;
  // Least cycles for a failure, rounded up.
  localparam int FAIL_CYC = (FAIL_NS + CLK_NS - 1) / CLK_NS;
  // Least stretch of the prescaled tick around a switch, in ns.
  localparam int STRETCH_NS = 200;
  localparam int STRETCH_CYC = (STRETCH_NS + CLK_NS - 1) / CLK_NS;
  // Swing edges seen before the oscillator reports ready.
  localparam logic [3:0] RDY_SWINGS = 4'hf;
  // Prescaler masks for the 1.024 kHz and 1 Hz ticks.
  localparam logic [14:0] PRE_KHZ = 15'h001f;
  localparam logic [14:0] PRE_HZ  = 15'h7fff;
  // Cycles after reset release before the backup pin is judged.
  localparam logic [1:0] BOOT_WAIT = 2'h3;
  // Backup domain supply state, one-hot.
  typedef enum logic [2:0] {
    PWR_MAIN   = 3'b001,
    PWR_SWITCH = 3'b010,
    PWR_BATT   = 3'b100
  } rcb_pwr_t;
  // Register port request.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rcb_bus_req_t;
  // Pins and reset events from outside the clock domain.
  typedef struct packed {
    logic pdi_rst;
    logic wdt_rst;
    logic bod_rst;
    logic pin_rst;
    logic main_low;
    logic vbat_present;
    logic vbat_low;
    logic xtal_swing;
  } rcb_pin_t;
  // Whole state of the block.
  typedef struct packed {
    rcb_pin_t    s1;
    rcb_pin_t    s2;
    rcb_pin_t    prev;
    logic [5:0]  cause;
    logic        sw_reset_request;
    logic        sysrst;
    logic [5:0]  bkctrl;
    logic        podf;
    logic        bodf;
    logic        fail;
    logic        rdy;
    logic        absent;
    logic [7:0]  bkreg0;
    logic [7:0]  bkreg1;
    logic [14:0] presc;
    logic [31:0] rtc;
    logic        rtc_tick;
    logic [17:0] fail_cnt;
    logic [3:0]  rdy_cnt;
    rcb_pwr_t    pwr;
    logic [4:0]  stretch;
    logic        pend;
    logic [1:0]  boot;
    logic        sw_open;
    logic [7:0]  rdata;
  } rcb_state_t;
endpackage

// file: core/rcb_top.sv
// Reset-cause recorder, software reset and backup power domain supervisor.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// - Software reset sets its cause flag.
// - Debug-port reset sets its cause flag.
// - Watchdog reset sets its cause flag.
// - Brownout reset sets its cause flag.
// - Pin reset sets its cause flag.
// - Power-on sets flag; only software clears.
// - Request bit issues reset, then clears.
// - Backup power-on sets flag, opens switch.
// - Sample battery at 1 Hz on battery.
// - After reset flag missing battery voltage.
// - Supply switch follows main brownout detector.
// - Prescaled output is 1.024 kHz or 1 Hz.
// - Monitor flags crystal stop when enabled.
// - Counter advances on each prescaled tick.
// - Two retention registers keep their values.
// - Main loss: switch, ignore, stretch, reset.
// - Domain runs on; registers closed without power.
// - Access enable gates domain; supervision flags open.
// - Failure only after 64 swings lost.
module rcb_top #(
  // Cycles without a swing before a failure is flagged.
  parameter logic [17:0] FAIL_CYCLES = 18'(rcb_pkg::FAIL_CYC)
) (
  // Clock and power-on reset.
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Register port.
  input  wire rcb_pkg::rcb_bus_req_t bus_req,
  input  wire logic                  ccp_unlock,
  output logic [7:0]                 rdata,
  // Pins and reset events.
  input  wire rcb_pkg::rcb_pin_t     pins,
  // System and domain outputs.
  output logic                       sys_reset_req,
  output logic                       unbacked_reset,
  output logic                       backup_on_vbat,
  output logic                       vbat_switch_closed,
  output logic                       high_esr_mode,
  output logic                       rtc_tick,
  output logic [31:0]                rtc_count
);

  // Registered and next state.
  rcb_pkg::rcb_state_t st_ff;
  rcb_pkg::rcb_state_t nxt_st;

  // Keeps set events ahead of clears.
  // set wins clear
  function automatic logic upd_flag(input logic cur, input logic set, input logic clr);
    upd_flag = (cur & ~clr) | set;
  endfunction

  // Edge of a synchronised pin.
  logic swing_edge;
  logic vbat_rise;
  // Prescaler ticks.
  logic tick_khz;
  logic tick_hz;
  logic tick_sel;
  // Access qualifiers.
  logic main_ok;
  logic dom_ok;
  // Decoded writes.
  logic wr_cause;
  logic wr_sw_reset_request;
  logic wr_bkctrl;
  logic wr_bkstat;
  logic wr_bkreg0;
  logic wr_bkreg1;
  logic [7:0] wd;
  logic bk_reset;
  logic absent_set;

  // Edges, ticks and write decode.
  always_comb
  begin
    wd         = bus_req.wdata;
    swing_edge = st_ff.s2.xtal_swing & ~st_ff.prev.xtal_swing;
    vbat_rise  = st_ff.s2.vbat_present & ~st_ff.prev.vbat_present;
    // The prescaler only runs while the crystal is enabled.
    tick_khz   = swing_edge & st_ff.bkctrl[rcb_pkg::BK_XEN] &
                 ((st_ff.presc & rcb_pkg::PRE_KHZ) == rcb_pkg::PRE_KHZ);
    tick_hz    = swing_edge & st_ff.bkctrl[rcb_pkg::BK_XEN] &
                 (st_ff.presc == rcb_pkg::PRE_HZ);
    tick_sel   = st_ff.bkctrl[rcb_pkg::BK_XSEL] ? tick_khz : tick_hz;
    main_ok    = (st_ff.pwr == rcb_pkg::PWR_MAIN);
    dom_ok     = main_ok & st_ff.bkctrl[rcb_pkg::BK_ACC];
    wr_cause   = bus_req.wr & (bus_req.addr == rcb_pkg::ADDR_CAUSE);
    wr_sw_reset_request   = bus_req.wr & (bus_req.addr == rcb_pkg::ADDR_SW_RESET_REQUEST) & ccp_unlock;
    wr_bkctrl  = bus_req.wr & (bus_req.addr == rcb_pkg::ADDR_BKCTRL) & main_ok;
    wr_bkstat  = bus_req.wr & (bus_req.addr == rcb_pkg::ADDR_BKSTAT) & main_ok;
    wr_bkreg0  = bus_req.wr & (bus_req.addr == rcb_pkg::ADDR_BKREG0) & dom_ok;
    wr_bkreg1  = bus_req.wr & (bus_req.addr == rcb_pkg::ADDR_BKREG1) & dom_ok;
    // Domain reset is protected and blocked by a same-write enable.
    bk_reset   = wr_bkctrl & dom_ok & ccp_unlock & wd[rcb_pkg::BK_RST] &
                 ~wd[rcb_pkg::BK_XEN] & ~wd[rcb_pkg::BK_FDEN];
    // Missing battery is judged once, on the last boot-wait cycle.
    absent_set = (st_ff.boot == rcb_pkg::BOOT_WAIT - 2'h1) & ~st_ff.s2.vbat_present;
  end

  // Next-state logic for the whole block.
  always_comb
  begin
    nxt_st = st_ff;
    // Two-stage synchronisers; the first stage feeds only the second.
    nxt_st.s1   = pins;
    nxt_st.s2   = st_ff.s1;
    nxt_st.prev = st_ff.s2;

    nxt_st.cause[rcb_pkg::CAUSE_SW]  = upd_flag(st_ff.cause[rcb_pkg::CAUSE_SW], st_ff.sysrst,
                                                wr_cause & wd[rcb_pkg::CAUSE_SW]);
    nxt_st.cause[rcb_pkg::CAUSE_DBG] = upd_flag(st_ff.cause[rcb_pkg::CAUSE_DBG], st_ff.s2.pdi_rst,
                                                wr_cause & wd[rcb_pkg::CAUSE_DBG]);
    nxt_st.cause[rcb_pkg::CAUSE_WDT] = upd_flag(st_ff.cause[rcb_pkg::CAUSE_WDT], st_ff.s2.wdt_rst,
                                                wr_cause & wd[rcb_pkg::CAUSE_WDT]);
    nxt_st.cause[rcb_pkg::CAUSE_BOD] = upd_flag(st_ff.cause[rcb_pkg::CAUSE_BOD], st_ff.s2.bod_rst,
                                                wr_cause & wd[rcb_pkg::CAUSE_BOD]);
    nxt_st.cause[rcb_pkg::CAUSE_PIN] = upd_flag(st_ff.cause[rcb_pkg::CAUSE_PIN], st_ff.s2.pin_rst,
                                                wr_cause & wd[rcb_pkg::CAUSE_PIN]);
    nxt_st.cause[rcb_pkg::CAUSE_POR] = upd_flag(st_ff.cause[rcb_pkg::CAUSE_POR], 1'b0,
                                                wr_cause & wd[rcb_pkg::CAUSE_POR]);

    nxt_st.sysrst = st_ff.sw_reset_request;
    if (st_ff.sw_reset_request)
    begin
      // The request is consumed as the reset pulse is issued.
      nxt_st.sw_reset_request = 1'b0;
    end
    else if (wr_sw_reset_request && wd[rcb_pkg::SW_RESET_REQUEST_BIT])
    begin
      // Only a protected write of one raises the request.
      nxt_st.sw_reset_request = 1'b1;
    end

    case (st_ff.pwr)
      rcb_pkg::PWR_MAIN:
      begin
        if (st_ff.s2.main_low)
        begin
          nxt_st.pwr     = rcb_pkg::PWR_SWITCH;
          nxt_st.stretch = 5'(rcb_pkg::STRETCH_CYC);
        end
      end
      rcb_pkg::PWR_SWITCH:
      begin
        // Hold here while the supply changes over.
        if (st_ff.stretch == 5'h00)
        begin
          nxt_st.pwr = st_ff.s2.main_low ? rcb_pkg::PWR_BATT : rcb_pkg::PWR_MAIN;
        end
        else
        begin
          nxt_st.stretch = st_ff.stretch - 5'h01;
        end
      end
      rcb_pkg::PWR_BATT:
      begin
        // Main power back: switch again with the same stretch.
        if (!st_ff.s2.main_low)
        begin
          nxt_st.pwr     = rcb_pkg::PWR_SWITCH;
          nxt_st.stretch = 5'(rcb_pkg::STRETCH_CYC);
        end
      end
      default:
      begin
        nxt_st.pwr = rcb_pkg::PWR_MAIN;
      end
    endcase

    if (vbat_rise && !main_ok)
    begin
      nxt_st.podf    = 1'b1;
      nxt_st.sw_open = 1'b1;
    end
    // Switch closes once software enables the crystal.
    else if (st_ff.bkctrl[rcb_pkg::BK_XEN])
    begin
      nxt_st.sw_open = 1'b0;
    end

    if (st_ff.boot != rcb_pkg::BOOT_WAIT)
    begin
      nxt_st.boot = st_ff.boot + 2'h1;
      if (absent_set)
      begin
        nxt_st.absent = 1'b1;
      end
    end

    if (tick_hz && st_ff.pwr == rcb_pkg::PWR_BATT && st_ff.s2.vbat_low)
    begin
      nxt_st.bodf = 1'b1;
    end

    if (wr_bkstat)
    begin
      nxt_st.podf   = upd_flag(st_ff.podf, vbat_rise & ~main_ok, wd[rcb_pkg::ST_PODF]);
      nxt_st.absent = upd_flag(st_ff.absent, absent_set, wd[rcb_pkg::ST_ABS]);
      nxt_st.bodf   = st_ff.bodf & ~wd[rcb_pkg::ST_BODF];
    end

    // Prescaler counts swing edges while the crystal is enabled.
    if (swing_edge && st_ff.bkctrl[rcb_pkg::BK_XEN])
    begin
      nxt_st.presc = st_ff.presc + 15'h0001;
      if (st_ff.rdy_cnt != rcb_pkg::RDY_SWINGS)
      begin
        nxt_st.rdy_cnt = st_ff.rdy_cnt + 4'h1;
      end
      else
      begin
        nxt_st.rdy = 1'b1;
      end
    end

    nxt_st.rtc_tick = 1'b0;
    if (st_ff.pwr == rcb_pkg::PWR_SWITCH)
    begin
      // A tick during the switch waits until it is over.
      nxt_st.pend = st_ff.pend | tick_sel;
    end
    else if (tick_sel || st_ff.pend)
    begin
      nxt_st.pend     = 1'b0;
      nxt_st.rtc      = st_ff.rtc + 32'h0000_0001;
      nxt_st.rtc_tick = 1'b1;
    end

    if (st_ff.bkctrl[rcb_pkg::BK_FDEN])
    begin
      if (swing_edge)
      begin
        nxt_st.fail_cnt = 18'h0_0000;
      end
      else if (st_ff.fail_cnt == FAIL_CYCLES)
      begin
        nxt_st.fail = 1'b1;
      end
      else
      begin
        nxt_st.fail_cnt = st_ff.fail_cnt + 18'h0_0001;
      end
    end
    // A failure event wins over a clearing write.
    if (wr_bkstat && dom_ok && wd[rcb_pkg::ST_FAIL])
    begin
      nxt_st.fail = st_ff.bkctrl[rcb_pkg::BK_FDEN] & ~swing_edge &
                    (st_ff.fail_cnt == FAIL_CYCLES);
    end

    // Backup control: access bit is always settable with main power.
    if (wr_bkctrl)
    begin
      nxt_st.bkctrl[rcb_pkg::BK_ACC] = st_ff.bkctrl[rcb_pkg::BK_ACC] | wd[rcb_pkg::BK_ACC];
      if (dom_ok)
      begin
        // Enables are write-one only.
        nxt_st.bkctrl[rcb_pkg::BK_XEN]  = st_ff.bkctrl[rcb_pkg::BK_XEN] | wd[rcb_pkg::BK_XEN];
        nxt_st.bkctrl[rcb_pkg::BK_FDEN] = st_ff.bkctrl[rcb_pkg::BK_FDEN] | wd[rcb_pkg::BK_FDEN];
        nxt_st.bkctrl[rcb_pkg::BK_HESR] = wd[rcb_pkg::BK_HESR];
        // Output selection is frozen once the crystal runs.
        if (!st_ff.bkctrl[rcb_pkg::BK_XEN])
        begin
          nxt_st.bkctrl[rcb_pkg::BK_XSEL] = wd[rcb_pkg::BK_XSEL];
        end
      end
    end

    // Domain reset clears oscillator setup and its status.
    if (bk_reset)
    begin
      nxt_st.bkctrl[rcb_pkg::BK_XEN]  = 1'b0;
      nxt_st.bkctrl[rcb_pkg::BK_FDEN] = 1'b0;
      nxt_st.bkctrl[rcb_pkg::BK_XSEL] = 1'b0;
      nxt_st.bkctrl[rcb_pkg::BK_HESR] = 1'b0;
      nxt_st.rdy      = 1'b0;
      nxt_st.rdy_cnt  = 4'h0;
      nxt_st.fail     = 1'b0;
      nxt_st.fail_cnt = 18'h0_0000;
      nxt_st.presc    = 15'h0000;
    end

    if (wr_bkreg0)
    begin
      nxt_st.bkreg0 = wd;
    end
    if (wr_bkreg1)
    begin
      nxt_st.bkreg1 = wd;
    end

    // Read data stand only in the cycle after the strobe.
    nxt_st.rdata = 8'h00;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        rcb_pkg::ADDR_CAUSE:
        begin
          nxt_st.rdata = {2'b00, st_ff.cause};
        end
        rcb_pkg::ADDR_SW_RESET_REQUEST:
        begin
          nxt_st.rdata = {7'h00, st_ff.sw_reset_request};
        end
        rcb_pkg::ADDR_BKCTRL:
        begin
          nxt_st.rdata = main_ok ? {2'b00, st_ff.bkctrl} : 8'h00;
        end
        rcb_pkg::ADDR_BKSTAT:
        begin
          // Supervision flags read with main power; the rest need access.
          nxt_st.rdata = main_ok ? {st_ff.absent, 3'b000, st_ff.rdy & dom_ok, st_ff.fail & dom_ok,
                                    st_ff.bodf, st_ff.podf} : 8'h00;
        end
        rcb_pkg::ADDR_BKREG0:
        begin
          nxt_st.rdata = dom_ok ? st_ff.bkreg0 : 8'h00;
        end
        rcb_pkg::ADDR_BKREG1:
        begin
          nxt_st.rdata = dom_ok ? st_ff.bkreg1 : 8'h00;
        end
        default:
        begin
          nxt_st.rdata = 8'h00;
        end
      endcase
    end
  end

  // State register; power-on reset loads constants only.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff       <= '0;
      st_ff.cause <= rcb_pkg::CAUSE_RST;
      st_ff.pwr   <= rcb_pkg::PWR_MAIN;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs, all from the state register.
  assign rdata              = st_ff.rdata;
  assign sys_reset_req      = st_ff.sysrst;
  assign unbacked_reset     = (st_ff.pwr != rcb_pkg::PWR_MAIN);
  assign backup_on_vbat     = (st_ff.pwr == rcb_pkg::PWR_BATT) & ~st_ff.sw_open;
  assign vbat_switch_closed = ~st_ff.sw_open;
  assign high_esr_mode      = st_ff.bkctrl[rcb_pkg::BK_HESR];
  assign rtc_tick           = st_ff.rtc_tick;
  assign rtc_count          = st_ff.rtc;

endmodule

// file: tb/rcb_checker.sv
// Assertion checker for the reset-cause and backup supervisor.
`timescale 1ns/1ps
module rcb_checker #(
  // Failure window, handed on from the block.
  parameter logic [17:0] FAIL_CYCLES = 18'h000c8
) (
  // Clock and reset.
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  // Register port.
  input wire rcb_pkg::rcb_bus_req_t bus_req,
  input wire logic                  ccp_unlock,
  input wire logic [7:0]            rdata,
  // Pins and outputs.
  input wire rcb_pkg::rcb_pin_t     pins,
  input wire logic                  sys_reset_req,
  input wire logic                  unbacked_reset,
  input wire logic                  backup_on_vbat,
  input wire logic                  rtc_tick,
  input wire logic [31:0]           rtc_count
);
  // All checks use the one clock and drop out in reset.
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_cause_resv: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == 3'h0 |-> rdata[7:6] == 2'h0) else $error("cause top bits set");
  a_sw_reset_request_pulse: assert property (
    bus_req.wr && bus_req.addr == 3'h1 && bus_req.wdata[0] && ccp_unlock |-> ##[1:3] sys_reset_req)
    else $error("no reset pulse");
  a_sysrst_single: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset pulse too long");
  a_vbat_unbacked: assert property (backup_on_vbat |-> unbacked_reset)
    else $error("battery without unbacked reset");
  a_main_loss: assert property ($rose(pins.main_low) |-> ##[1:6] unbacked_reset)
    else $error("late main loss response");
  a_main_back: assert property ($fell(pins.main_low) |-> ##[1:40] !unbacked_reset)
    else $error("no return to main");
  a_tick_stretch: assert property ($rose(unbacked_reset) |-> !rtc_tick [*8])
    else $error("tick while switching");
  a_rtc_step: assert property (
    $changed(rtc_count) && rtc_count != 32'h0 |-> rtc_count == $past(rtc_count) + 32'h1) else $error("count jump");
  a_closed_bk: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) >= 3'h2 && $past(unbacked_reset) |-> rdata == 8'h00)
    else $error("domain read without power");

  // Main scenarios reached.
  c_sw_reset_request: cover property (sys_reset_req);
  c_battery: cover property (backup_on_vbat);
  c_tick: cover property (rtc_tick);
endmodule

bind rcb_top rcb_checker #(.FAIL_CYCLES(FAIL_CYCLES)) i_chk (.ref_clk, .rst_n, .bus_req, .ccp_unlock, .rdata,
  .pins, .sys_reset_req, .unbacked_reset, .backup_on_vbat, .rtc_tick, .rtc_count);

// file: tb/rcb_supply_model.sv
// Model of the battery, the main brownout detector and the crystal.
`timescale 1ns/1ps
module rcb_supply_model #(
  // Crystal half period, sped up so ticks come in a few hundred cycles.
  parameter int HALF_NS = 50
) (
  // Commands from the bench.
  input  wire logic main_off,
  input  wire logic batt_on,
  input  wire logic xtal_run,
  // Levels seen by the block.
  output logic      main_low,
  output logic      vbat_present,
  output logic      vbat_low,
  output logic      xtal_swing
);
  assign main_low = main_off;
  assign vbat_present = batt_on;
  // A missing battery reads as below threshold.
  assign vbat_low = ~batt_on;

  // The crystal swings while it runs; a stopped one freezes at its level.
  initial
  begin
    xtal_swing = 1'b0;
    forever
    begin
      #(HALF_NS);
      if (xtal_run)
        xtal_swing = ~xtal_swing;
    end
  end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the reset-cause and backup supervisor.
`timescale 1ns/1ps
module tb_top;
  // A read note: expected value and the bits that count.
  typedef struct packed {
    logic [7:0] val;
    logic [7:0] msk;
  } rcb_exp_t;
  // Clock, reset and register port.
  logic                  ref_clk;
  logic                  rst_n;
  rcb_pkg::rcb_bus_req_t bus_req;
  logic                  ccp_unlock;
  logic [7:0]            rdata;
  // Events {debug, watchdog, brownout, pin}, supply commands and levels.
  logic [3:0]            ev;
  logic                  main_off;
  logic                  batt_on;
  logic                  xtal_run;
  logic [3:0]            sup;
  rcb_pkg::rcb_pin_t     pins;
  // Block outputs.
  logic                  sys_reset_req;
  logic                  unbacked_reset;
  logic                  backup_on_vbat;
  logic                  vbat_switch_closed;
  logic                  high_esr_mode;
  logic                  rtc_tick;
  logic [31:0]           rtc_count;
  // Scoreboard and counters.
  rcb_exp_t              q[$];
  rcb_exp_t              ex;
  logic                  rd_d = 1'b0;
  int                    err_total = 0;
  int                    comparisons = 0;
  int                    cyc = 0;
  int                    n_sr = 0;
  int                    gap = 0;
  int                    last_tk = 0;
  logic [7:0]            d0;
  logic [31:0]           cnt0;

  assign pins = {ev, sup};

  rcb_top #(.FAIL_CYCLES(18'h000c8)) i_dut (.ref_clk, .rst_n, .bus_req, .ccp_unlock, .rdata, .pins,
    .sys_reset_req, .unbacked_reset, .backup_on_vbat, .vbat_switch_closed, .high_esr_mode, .rtc_tick,
    .rtc_count);
  rcb_supply_model i_sup (.main_off, .batt_on, .xtal_run, .main_low(sup[3]), .vbat_present(sup[2]),
    .vbat_low(sup[1]), .xtal_swing(sup[0]));

  // Free-running 100 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever
      #5 ref_clk = ~ref_clk;
  end

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Waits a number of clock edges.
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One register cycle and a quiet cycle; a read leaves its note.
  task automatic op(input logic [2:0] a, input logic [7:0] d, input logic w, input rcb_exp_t e);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w)
      q.push_back(e);
    @(posedge ref_clk);
    bus_req <= '0;
    @(posedge ref_clk);
  endtask

  // Register write.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    op(a, d, 1'b1, '0);
  endtask

  // Register read with the value expected under a mask.
  task automatic rd(input logic [2:0] a, input logic [7:0] v, input logic [7:0] m = 8'hff);
    op(a, 8'h00, 1'b0, '{val: v, msk: m});
  endtask

  // Watches read data, reset pulses, tick spacing and the hang limit.
  always @(posedge ref_clk)
  begin
    rd_d <= bus_req.rd;
    cyc <= cyc + 1;
    if (rd_d === 1'b1)
    begin
      ex = q.pop_front();
      chk("rdata", {24'h0, rdata & ex.msk}, {24'h0, ex.val & ex.msk});
    end
    if (sys_reset_req === 1'b1)
      n_sr <= n_sr + 1;
    if (rtc_tick === 1'b1)
    begin
      gap <= cyc - last_tk;
      last_tk <= cyc;
    end
    if (cyc == 10000)
    begin
      err_total++;
      complete_run();
    end
  end

  // Main sequence.
  initial
  begin
    rst_n = 1'b0;
    bus_req = '0;
    ccp_unlock = 1'b0;
    ev = 4'h0;
    main_off = 1'b0;
    batt_on = 1'b1;
    xtal_run = 1'b1;
    void'($urandom(32'h9bac));
    wt(2);
    rst_n <= 1'b1;
    wt(4);
    rd(3'h0, 8'h01);
    rd(3'h7, 8'h00);
    rd(3'h3, 8'h00);
    wr(3'h0, 8'h01);
    rd(3'h0, 8'h00);
    // Each event against a clear swept across its arrival.
    for (int i = 0; i < 4; i++)
      for (int k = 0; k < 5; k++)
      begin
        fork
          begin
            ev[i] <= 1'b1;
            wt(2);
            ev[i] <= 1'b0;
          end
          begin
            wt(k);
            wr(3'h0, 8'h01 << (i + 1));
          end
        join
        wt(8);
        // The latest clear lands after the event and removes the flag.
        rd(3'h0, (k == 4) ? 8'h00 : 8'h01 << (i + 1));
        wr(3'h0, 8'h3f);
      end
    rd(3'h0, 8'h00);
    // A locked request is ignored, an unlocked one issues one reset.
    wr(3'h1, 8'h01);
    wt(4);
    chk("sw_reset_request_locked", n_sr, 0);
    ccp_unlock <= 1'b1;
    wr(3'h1, 8'h01);
    ccp_unlock <= 1'b0;
    wt(4);
    chk("sw_reset_request_pulse", n_sr, 1);
    rd(3'h1, 8'h00);
    rd(3'h0, 8'h20);
    d0 = 8'($urandom);
    wr(3'h4, d0);
    rd(3'h4, 8'h00);
    wr(3'h2, 8'h02);
    ccp_unlock <= 1'b1;
    wr(3'h2, 8'h01);
    ccp_unlock <= 1'b0;
    wr(3'h2, 8'h32);
    chk("high_esr", high_esr_mode, 1);
    wr(3'h2, 8'h36);
    wr(3'h2, 8'h3e);
    wt(250);
    rd(3'h3, 8'h08);
    wr(3'h4, d0);
    wr(3'h5, ~d0);
    rd(3'h4, d0);
    rd(3'h5, ~d0);
    wt(700);
    chk("tick_gap", gap, 320);
    // Crystal stop below and above the failure window.
    xtal_run <= 1'b0;
    wt(150);
    rd(3'h3, 8'h00, 8'h04);
    wt(100);
    rd(3'h3, 8'h04, 8'h04);
    xtal_run <= 1'b1;
    // Let the swings resume, or the standing failure sets the flag again.
    wt(30);
    wr(3'h3, 8'h04);
    rd(3'h3, 8'h00, 8'h04);
    // Main power loss and return.
    cnt0 = rtc_count;
    main_off <= 1'b1;
    wt(40);
    chk("on_battery", {vbat_switch_closed, backup_on_vbat, unbacked_reset}, 7);
    rd(3'h4, 8'h00);
    // A battery reinserted while off main power raises its power-on flag.
    batt_on <= 1'b0;
    wt(10);
    batt_on <= 1'b1;
    wt(390);
    main_off <= 1'b0;
    wt(40);
    chk("on_main", {vbat_switch_closed, backup_on_vbat, unbacked_reset}, 4);
    rd(3'h3, 8'h01, 8'h01);
    rd(3'h4, d0);
    chk("count_ran", {31'h0, rtc_count > cnt0}, 1);
    // Second power-on with the battery gone.
    batt_on <= 1'b0;
    wt(4);
    rst_n <= 1'b0;
    wt(2);
    rst_n <= 1'b1;
    wt(4);
    rd(3'h0, 8'h01);
    rd(3'h3, 8'h80, 8'h80);
    wr(3'h3, 8'h80);
    rd(3'h3, 8'h00, 8'h80);
    complete_run();
  end
endmodule
